// File: pkg/timer_pkg.sv
// Notes on behaviour
// [RULE1] external-qualify set: count only while gate pin high and run bit set.
// [RULE2] source select set counts event pin falls; clear counts machine cycles.
// [RULE3] two mode bits: 00 prescaled, 01 16-bit, 10 auto-reload, 11 split/halt.
// [RULE4] mode 0 is 13 bits: high byte over low five low-byte bits.
// [RULE5] wrap from all ones to zero sets the unit overflow flag.
// [RULE6] setting a run bit never disturbs the count registers.
// [RULE7] mode register bit 7 qualifies unit 1, bit 3 qualifies unit 0.
// [RULE8] mode 1 counts all 16 bits of high and low bytes together.
// [RULE9] mode 2 low byte overflow sets flag and reloads it from high byte.
// [RULE10] unit 1 in mode 3 holds its count as if stopped.
// [RULE11] split mode: unit 0 low byte uses all unit 0 controls and flag.
// [RULE12] split mode: unit 0 high byte counts cycles, run and flag of unit 1.
// [RULE13] with unit 0 split, unit 1 still counts but loses its flag.
// [RULE14] timer operation advances once per machine cycle of six clocks.
// [RULE15] event pin sampled each machine cycle; high then low counts one.
// [RULE16] overflow flag clears when the processor vectors to its routine.
// [RULE17] software starts and stops each unit through its run bit.
`default_nettype none
package timer_pkg;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned OSC_PER_MC = 6;
  localparam int unsigned MC_NS = OSC_PER_MC * CLK_PERIOD_NS;
  localparam int unsigned MC_CYCLES = MC_NS / CLK_PERIOD_NS;
  localparam logic [2:0] MC_LAST = 3'(MC_CYCLES - 1);

  localparam logic [7:0] IDX_CTRL = 8'h88;
  localparam logic [7:0] IDX_MODE = 8'h89;
  localparam logic [7:0] IDX_LOW0 = 8'h8A;
  localparam logic [7:0] IDX_LOW1 = 8'h8B;
  localparam logic [7:0] IDX_HIGH0 = 8'h8C;
  localparam logic [7:0] IDX_HIGH1 = 8'h8D;
  localparam logic [7:0] IDX_IRQ_STAT = 8'h90;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h91;

  // mode register fields, unit 1 in the upper nibble
  localparam int unsigned MODE_GATE1 = 7;
  localparam int unsigned MODE_SRC1 = 6;
  localparam int unsigned MODE_SEL1_LSB = 4;
  localparam int unsigned MODE_GATE0 = 3;
  localparam int unsigned MODE_SRC0 = 2;
  localparam int unsigned MODE_SEL0_LSB = 0;
  localparam int unsigned CTRL_OVF1 = 7;
  localparam int unsigned CTRL_RUN1 = 6;
  localparam int unsigned CTRL_OVF0 = 5;
  localparam int unsigned CTRL_RUN0 = 4;
  localparam int unsigned IRQ_U0 = 0;
  localparam int unsigned IRQ_U1 = 1;

  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam logic [1:0] IRQ_RST = 2'h0;

  typedef enum logic [1:0] {
    MODE_PRESCALED, MODE_CASCADED, MODE_RELOAD, MODE_SPLIT
  } mode_t;

  function automatic logic [11:0] byte_addr(input logic [7:0] idx);
    byte_addr = {2'h0, idx, 2'h0};
  endfunction : byte_addr

  // one count step: returns {overflow, high, low}
  function automatic logic [16:0] count_step(input mode_t m,
      input logic [7:0] hi, input logic [7:0] lo);
    logic [13:0] s13;
    logic [16:0] s16;
    logic [8:0] s8;
    s13 = {1'b0, hi, lo[4:0]} + 14'h1;
    s16 = {1'b0, hi, lo} + 17'h1;
    s8 = {1'b0, lo} + 9'h1;
    case (m)
      MODE_PRESCALED: count_step = {s13[13], s13[12:5], lo[7:5], s13[4:0]};
      MODE_CASCADED: count_step = s16;
      MODE_RELOAD: count_step = {s8[8], hi, s8[8] ? hi : s8[7:0]};
      default: count_step = {1'b0, hi, lo};
    endcase
  endfunction : count_step
endpackage : timer_pkg
`default_nettype wire

// File: pkg/sample_if.sv
`timescale 1ns/10ps
`default_nettype none
interface sample_if;
  logic tick;
  logic pin;
  logic fall;
  modport sampler(input tick, input pin, output fall);
  modport user(output tick, output pin, input fall);
endinterface : sample_if
`default_nettype wire

// File: design/event_sampler.sv
`timescale 1ns/10ps
`default_nettype none
module event_sampler (
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  input wire logic ce, // clock enable
  sample_if.sampler link // tick in, pin in, fall out
);
  logic last_reg;
  logic fall_reg;

  // the fall stays up for a whole machine cycle so the count lands in
  // the cycle after detection; last starts low so reset makes no edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_reg <= 1'b0;
      fall_reg <= 1'b0;
    end else if (ce && link.tick) begin
      last_reg <= link.pin; // [RULE15]
      fall_reg <= last_reg & ~link.pin; // [RULE15]
    end
  end

  assign link.fall = fall_reg;

  property p_fall_seen;
    @(posedge pclk) disable iff (!presetn)
    ce && link.tick && last_reg && !link.pin |=> link.fall;
  endproperty
  a_fall_seen: assert property (p_fall_seen) // [RULE15]
    else $error("sampled high then low gave no count event");
endmodule : event_sampler
`default_nettype wire

// File: design/dual_timer.sv
// Our own choice: the APB slave port.
`timescale 1ns/10ps
`default_nettype none
module dual_timer (
  input wire logic pclk, // system clock, 100 MHz
  input wire logic presetn, // async reset, active low
  input wire logic ce, // clock enable, freezes all state when low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error, unmapped address
  input wire logic event_pin_unit0, // external event input, unit 0
  input wire logic event_pin_unit1, // external event input, unit 1
  input wire logic gate_pin_unit0, // gate input, unit 0
  input wire logic gate_pin_unit1, // gate input, unit 1
  input wire logic vector_ack_unit0, // processor vectors, unit 0
  input wire logic vector_ack_unit1, // processor vectors, unit 1
  output logic overflow_flag_unit0, // overflow flag, unit 0
  output logic overflow_flag_unit1, // overflow flag, unit 1
  output logic irq // level interrupt
);
  import timer_pkg::*;

  logic [7:0] mode_reg;
  logic run0_reg, run1_reg, ovf0_reg, ovf1_reg;
  logic [7:0] low0_reg, high0_reg, low1_reg, high1_reg;
  logic [1:0] stat_reg, mask_reg, stat_next;
  logic [31:0] prdata_reg;
  logic pready_reg, pslverr_reg, irq_reg;
  logic [2:0] mc_cnt_reg;
  logic [7:0] low0_next, high0_next, low1_next, high1_next;
  logic wr_en, rd_en, tick, setup;
  logic en0, en1, inc0, inc1, inc0h;
  logic set0, set1, set1h, ov1;
  mode_t mode0, mode1;

  sample_if s0 ();
  sample_if s1 ();

  assign s0.tick = tick;
  assign s0.pin = event_pin_unit0;
  assign s1.tick = tick;
  assign s1.pin = event_pin_unit1;

  event_sampler u_samp0 (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .link(s0)
  );

  event_sampler u_samp1 (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .link(s1)
  );

  function automatic logic wr_to(input logic [7:0] idx);
    wr_to = wr_en && (paddr == byte_addr(idx));
  endfunction : wr_to

  // no wait state: setup latches read data, access completes in its first cycle
  assign setup = psel && !penable;
  assign wr_en = psel && penable && pwrite && pready_reg;
  assign rd_en = psel && penable && !pwrite && pready_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mc_cnt_reg <= 3'h0;
    end else if (ce) begin
      mc_cnt_reg <= (mc_cnt_reg == MC_LAST) ? 3'h0 : mc_cnt_reg + 3'h1;
    end
  end

  assign tick = ce && (mc_cnt_reg == MC_LAST); // [RULE14]

  assign mode0 = mode_t'(mode_reg[MODE_SEL0_LSB +: 2]); // [RULE3]
  assign mode1 = mode_t'(mode_reg[MODE_SEL1_LSB +: 2]); // [RULE3]

  // gating and source selection per unit
  assign en0 = run0_reg && (!mode_reg[MODE_GATE0] || gate_pin_unit0); // [RULE1] [RULE7]
  assign en1 = run1_reg && (!mode_reg[MODE_GATE1] || gate_pin_unit1); // [RULE1] [RULE7]
  assign inc0 = tick && en0 && (!mode_reg[MODE_SRC0] || s0.fall); // [RULE2] [RULE11]
  assign inc1 = tick && en1 && (!mode_reg[MODE_SRC1] || s1.fall)
    && (mode1 != MODE_SPLIT); // [RULE2] [RULE10] [RULE13]
  // split high byte: machine cycles only, run bit of unit 1, no gate
  assign inc0h = tick && run1_reg && (mode0 == MODE_SPLIT); // [RULE12]

  always_comb begin
    low0_next = low0_reg;
    high0_next = high0_reg;
    set0 = 1'b0;
    set1h = 1'b0;
    if (mode0 == MODE_SPLIT) begin
      if (inc0) begin
        {set0, low0_next} = {1'b0, low0_reg} + 9'h1; // [RULE11] [RULE5]
      end
      if (inc0h) begin
        {set1h, high0_next} = {1'b0, high0_reg} + 9'h1; // [RULE12]
      end
    end else if (inc0) begin
      {set0, high0_next, low0_next} =
        count_step(mode0, high0_reg, low0_reg); // [RULE4] [RULE8] [RULE9]
    end
  end

  always_comb begin
    low1_next = low1_reg;
    high1_next = high1_reg;
    ov1 = 1'b0;
    if (inc1) begin
      {ov1, high1_next, low1_next} =
        count_step(mode1, high1_reg, low1_reg); // [RULE4] [RULE8] [RULE9]
    end
  end

  // unit 1 keeps counting under split but its flag belongs to unit 0
  assign set1 = set1h || (ov1 && mode0 != MODE_SPLIT); // [RULE13] [RULE5]

  // software write beats a count step in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low0_reg <= COUNT_RST;
      high0_reg <= COUNT_RST;
    end else if (ce) begin
      low0_reg <= wr_to(IDX_LOW0) ? pwdata[7:0] : low0_next;
      high0_reg <= wr_to(IDX_HIGH0) ? pwdata[7:0] : high0_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low1_reg <= COUNT_RST;
      high1_reg <= COUNT_RST;
    end else if (ce) begin
      low1_reg <= wr_to(IDX_LOW1) ? pwdata[7:0] : low1_next;
      high1_reg <= wr_to(IDX_HIGH1) ? pwdata[7:0] : high1_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg <= MODE_RST;
    end else if (ce && wr_to(IDX_MODE)) begin
      mode_reg <= pwdata[7:0];
    end
  end

  // run bits only gate counting; counts are untouched by them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run0_reg <= 1'b0;
      run1_reg <= 1'b0;
    end else if (ce && wr_to(IDX_CTRL)) begin
      run0_reg <= pwdata[CTRL_RUN0]; // [RULE6]
      run1_reg <= pwdata[CTRL_RUN1]; // [RULE6]
    end
  end

  // hardware set wins over vector clear and software clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovf0_reg <= 1'b0;
      ovf1_reg <= 1'b0;
    end else if (ce) begin
      ovf0_reg <= set0 || (!vector_ack_unit0 &&
        (wr_to(IDX_CTRL) ? pwdata[CTRL_OVF0] : ovf0_reg)); // [RULE5] [RULE16]
      ovf1_reg <= set1 || (!vector_ack_unit1 &&
        (wr_to(IDX_CTRL) ? pwdata[CTRL_OVF1] : ovf1_reg)); // [RULE5] [RULE16]
    end
  end

  // read clears only the bits that the read returned, so an event
  // between setup and access is kept
  always_comb begin
    stat_next = stat_reg;
    if (rd_en && paddr == byte_addr(IDX_IRQ_STAT)) begin
      stat_next = stat_reg & ~prdata_reg[1:0];
    end
    stat_next[IRQ_U0] = stat_next[IRQ_U0] | set0;
    stat_next[IRQ_U1] = stat_next[IRQ_U1] | set1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_reg <= IRQ_RST;
      mask_reg <= IRQ_RST;
      irq_reg <= 1'b0;
    end else if (ce) begin
      stat_reg <= stat_next;
      if (wr_to(IDX_IRQ_MASK)) begin
        mask_reg <= pwdata[1:0];
      end
      irq_reg <= |(stat_next & mask_reg);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else if (ce) begin
      pready_reg <= setup;
      if (setup) begin
        pslverr_reg <= 1'b0;
        case (paddr)
          byte_addr(IDX_CTRL): prdata_reg <= {24'h0, ovf1_reg, run1_reg,
            ovf0_reg, run0_reg, 4'h0};
          byte_addr(IDX_MODE): prdata_reg <= {24'h0, mode_reg};
          byte_addr(IDX_LOW0): prdata_reg <= {24'h0, low0_reg};
          byte_addr(IDX_LOW1): prdata_reg <= {24'h0, low1_reg};
          byte_addr(IDX_HIGH0): prdata_reg <= {24'h0, high0_reg};
          byte_addr(IDX_HIGH1): prdata_reg <= {24'h0, high1_reg};
          byte_addr(IDX_IRQ_STAT): prdata_reg <= {30'h0, stat_reg};
          byte_addr(IDX_IRQ_MASK): prdata_reg <= {30'h0, mask_reg};
          default: begin
            prdata_reg <= 32'h0000_0000;
            pslverr_reg <= 1'b1;
          end
        endcase
      end
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign overflow_flag_unit0 = ovf0_reg;
  assign overflow_flag_unit1 = ovf1_reg;
  assign irq = irq_reg;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_tick_gap;
    !tick [*5];
  endsequence

  property p_mc_rate;
    tick |=> s_tick_gap;
  endproperty
  a_mc_rate: assert property (p_mc_rate) // [RULE14]
    else $error("machine cycle tick faster than six clocks");

  property p_gate_hold;
    ce && !wr_en && mode_reg[MODE_GATE0] && !gate_pin_unit0
      && mode0 != MODE_SPLIT |=> $stable({high0_reg, low0_reg});
  endproperty
  a_gate_hold: assert property (p_gate_hold) // [RULE1]
    else $error("unit 0 counted while gate pin low");

  property p_src_hold;
    ce && !wr_en && mode_reg[MODE_SRC0] && !s0.fall
      && mode0 != MODE_SPLIT |=> $stable({high0_reg, low0_reg});
  endproperty
  a_src_hold: assert property (p_src_hold) // [RULE2]
    else $error("counter source advanced without a falling edge");

  property p_m0_carry;
    ce && !wr_en && inc0 && mode0 == MODE_PRESCALED
      && low0_reg[4:0] == 5'h1F && high0_reg != 8'hFF
      |=> high0_reg == $past(high0_reg) + 8'h1 && low0_reg[4:0] == 5'h00
      && low0_reg[7:5] == $past(low0_reg[7:5]);
  endproperty
  a_m0_carry: assert property (p_m0_carry) // [RULE4]
    else $error("13-bit carry into high byte wrong");

  property p_m1_carry;
    ce && !wr_en && inc0 && mode0 == MODE_CASCADED
      && low0_reg == 8'hFF && high0_reg != 8'hFF
      |=> high0_reg == $past(high0_reg) + 8'h1 && low0_reg == 8'h00;
  endproperty
  a_m1_carry: assert property (p_m1_carry) // [RULE8]
    else $error("16-bit carry into high byte wrong");

  property p_ovf_flag;
    ce && !wr_en && inc0 && mode0 == MODE_CASCADED
      && {high0_reg, low0_reg} == 16'hFFFF
      |=> ovf0_reg && stat_reg[IRQ_U0] && {high0_reg, low0_reg} == 16'h0000;
  endproperty
  a_ovf_flag: assert property (p_ovf_flag) // [RULE5]
    else $error("wrap did not set overflow flag");

  sequence s_reload_cause;
    ce && !wr_en && inc0 && mode0 == MODE_RELOAD && low0_reg == 8'hFF;
  endsequence

  sequence s_reload_effect;
    low0_reg == $past(high0_reg) && $stable(high0_reg) && ovf0_reg;
  endsequence

  property p_reload;
    s_reload_cause |=> s_reload_effect;
  endproperty
  a_reload: assert property (p_reload) // [RULE9]
    else $error("auto-reload did not copy high byte");

  property p_unit1_halt;
    ce && !wr_en && mode1 == MODE_SPLIT |=> $stable({high1_reg, low1_reg});
  endproperty
  a_unit1_halt: assert property (p_unit1_halt) // [RULE10]
    else $error("unit 1 counted in split mode");

  property p_split_high;
    ce && !wr_en && mode0 == MODE_SPLIT && tick && run1_reg
      && high0_reg == 8'hFF |=> high0_reg == 8'h00 && ovf1_reg;
  endproperty
  a_split_high: assert property (p_split_high) // [RULE12]
    else $error("split high byte did not set unit 1 flag");

  property p_flag_taken;
    ce && !wr_en && mode0 == MODE_SPLIT && !inc0h && !ovf1_reg |=> !ovf1_reg;
  endproperty
  a_flag_taken: assert property (p_flag_taken) // [RULE13]
    else $error("unit 1 set its flag while unit 0 split");

  property p_run_keeps;
    ce && wr_to(IDX_CTRL) && pwdata[CTRL_RUN0] && !run0_reg && !inc0h
      |=> $stable({high0_reg, low0_reg});
  endproperty
  a_run_keeps: assert property (p_run_keeps) // [RULE6]
    else $error("setting run bit changed the count");

  property p_vector_clear;
    ce && vector_ack_unit0 && !set0 |=> !ovf0_reg;
  endproperty
  a_vector_clear: assert property (p_vector_clear) // [RULE16]
    else $error("vector acknowledge did not clear flag");
endmodule : dual_timer
`default_nettype wire

// File: tb/pin_driver.sv
`timescale 1ns/10ps
`default_nettype none
module pin_driver (
  input wire logic pclk, // clock
  input wire logic presetn, // reset, active low
  input wire logic go, // start a burst of falls
  input wire logic sel, // unit whose event pin pulses
  input wire logic [7:0] n_falls, // falls in the burst
  input wire logic [1:0] gate_set, // wanted gate levels
  output logic [1:0] ev, // event pins, unit 1 in bit 1
  output logic [1:0] gate, // gate pins, unit 1 in bit 1
  output logic busy // burst still running
);
  logic [7:0] left;
  logic [3:0] ph;
  logic unit;
  // each level stands six clocks so every level is sampled once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      left <= 8'h00;
      ph <= 4'h0;
      unit <= 1'b0;
    end else if (go) begin
      left <= n_falls;
      ph <= 4'h0;
      unit <= sel;
    end else if (left != 8'h00) begin
      ph <= (ph == 4'hB) ? 4'h0 : ph + 4'h1;
      left <= (ph == 4'hB) ? left - 8'h01 : left;
    end
  end
  // idle low keeps a pin quiet; a pulse is one rise then one fall
  assign ev = (left != 8'h00 && ph < 4'h6) ? (unit ? 2'h2 : 2'h1) : 2'h0;
  assign gate = gate_set;
  assign busy = left != 8'h00;
endmodule : pin_driver
`default_nettype wire

// File: tb/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import timer_pkg::*;
  typedef struct packed {
    logic [7:0] mode;
    logic unit;
    logic [1:0] gate;
    logic [7:0] hi;
    logic [7:0] lo;
    logic [7:0] ticks;
    logic [7:0] ehi;
    logic [7:0] elo;
    logic [1:0] estat;
  } row_t;
  row_t rows [0:11] = '{
    '{8'h00, 1'b0, 2'h0, 8'hFF, 8'hFE, 8'h03, 8'h00, 8'hE1, 2'h1},
    '{8'h01, 1'b0, 2'h0, 8'hFF, 8'hFE, 8'h03, 8'h00, 8'h01, 2'h1},
    '{8'h02, 1'b0, 2'h0, 8'hF0, 8'hFE, 8'h03, 8'hF0, 8'hF1, 2'h1},
    '{8'h10, 1'b1, 2'h0, 8'h12, 8'h34, 8'h05, 8'h12, 8'h39, 2'h0},
    '{8'h30, 1'b1, 2'h0, 8'h12, 8'h34, 8'h05, 8'h12, 8'h34, 2'h0},
    '{8'h20, 1'b1, 2'h0, 8'h80, 8'hFF, 8'h02, 8'h80, 8'h81, 2'h2},
    '{8'h09, 1'b0, 2'h0, 8'h00, 8'h10, 8'h04, 8'h00, 8'h10, 2'h0},
    '{8'h09, 1'b0, 2'h1, 8'h00, 8'h10, 8'h04, 8'h00, 8'h14, 2'h0},
    '{8'h81, 1'b0, 2'h0, 8'h00, 8'h10, 8'h04, 8'h00, 8'h14, 2'h0},
    '{8'h90, 1'b1, 2'h1, 8'h00, 8'h10, 8'h04, 8'h00, 8'h10, 2'h0},
    '{8'h00, 1'b0, 2'h0, 8'h12, 8'h5F, 8'h01, 8'h13, 8'h40, 2'h0},
    '{8'h00, 1'b1, 2'h0, 8'hFF, 8'hFF, 8'h01, 8'h00, 8'hE0, 2'h2}};
  logic [7:0] regs [0:7] = '{IDX_CTRL, IDX_MODE, IDX_LOW0, IDX_LOW1,
    IDX_HIGH0, IDX_HIGH1, IDX_IRQ_STAT, IDX_IRQ_MASK};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic ack0 = 1'b0;
  logic ack1 = 1'b0;
  logic ovf0;
  logic ovf1;
  logic irq;
  logic [1:0] ev;
  logic [1:0] gate;
  logic go = 1'b0;
  logic sel = 1'b0;
  logic [7:0] n_falls = 8'h00;
  logic [1:0] gate_set = 2'h0;
  logic busy;
  logic [31:0] q;
  logic err;
  row_t r;
  int fail_count = 0;
  int samples_checked = 0;
  int cycles = 0;

  dual_timer dut_u (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .event_pin_unit0(ev[0]), .event_pin_unit1(ev[1]),
    .gate_pin_unit0(gate[0]), .gate_pin_unit1(gate[1]),
    .vector_ack_unit0(ack0), .vector_ack_unit1(ack1),
    .overflow_flag_unit0(ovf0), .overflow_flag_unit1(ovf1), .irq(irq));
  pin_driver pins_u (.pclk(pclk), .presetn(presetn), .go(go), .sel(sel),
    .n_falls(n_falls), .gate_set(gate_set), .ev(ev), .gate(gate),
    .busy(busy));

  always #5 pclk = ~pclk;

  task automatic results();
    $display("checked=%0d failed=%0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : results

  // the global cycle ceiling is what ends a slave that never answers
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      results();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic apb(input logic w, input logic [7:0] idx,
      input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle edge, so a following call never reassigns psel in this step
    @(posedge pclk);
  endtask : apb

  task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 8'h00);
    check(q, exp);
  endtask : rd_chk

  // run bits stand for exactly 6*t edges, so exactly t ticks land
  task automatic run(input logic [7:0] bits, input logic [7:0] t);
    apb(1'b1, IDX_CTRL, bits);
    // the idle edge after the first write already counts as one of them
    repeat (OSC_PER_MC * t - 3) @(posedge pclk);
    apb(1'b1, IDX_CTRL, 8'h00);
  endtask : run

  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (regs[i]) rd_chk(regs[i], 32'h0);
    check({ovf1, ovf0, irq}, 32'h0);
    apb(1'b1, IDX_MODE, 8'hA5);
    rd_chk(IDX_MODE, 32'hA5);
    apb(1'b0, 8'h92, 8'h00);
    check({31'h0, err}, 32'h1);
    check(q, 32'h0);
    foreach (rows[i]) begin
      r = rows[i];
      gate_set <= r.gate;
      apb(1'b1, IDX_MODE, r.mode);
      apb(1'b1, r.unit ? IDX_HIGH1 : IDX_HIGH0, r.hi);
      apb(1'b1, r.unit ? IDX_LOW1 : IDX_LOW0, r.lo);
      apb(1'b0, IDX_IRQ_STAT, 8'h00);
      run(r.unit ? 8'h40 : 8'h10, r.ticks);
      rd_chk(r.unit ? IDX_HIGH1 : IDX_HIGH0, {24'h0, r.ehi});
      rd_chk(r.unit ? IDX_LOW1 : IDX_LOW0, {24'h0, r.elo});
      rd_chk(IDX_IRQ_STAT, {30'h0, r.estat});
      check(irq, 1'b0);
    end
    gate_set <= 2'h0;
    for (int u = 0; u < 2; u++) begin
      apb(1'b1, IDX_MODE, u ? 8'h50 : 8'h05);
      apb(1'b1, u ? IDX_LOW1 : IDX_LOW0, 8'h00);
      apb(1'b1, u ? IDX_HIGH1 : IDX_HIGH0, 8'h00);
      apb(1'b1, IDX_CTRL, u ? 8'h40 : 8'h10);
      sel <= u[0];
      n_falls <= 8'h04;
      go <= 1'b1;
      @(posedge pclk);
      go <= 1'b0;
      @(posedge pclk);
      while (busy !== 1'b0) @(posedge pclk);
      repeat (4 * OSC_PER_MC) @(posedge pclk);
      apb(1'b1, IDX_CTRL, 8'h00);
      rd_chk(u ? IDX_LOW1 : IDX_LOW0, 32'h4);
    end
    apb(1'b1, IDX_IRQ_MASK, 8'h03);
    apb(1'b1, IDX_MODE, 8'h13);
    apb(1'b1, IDX_LOW0, 8'hFE);
    apb(1'b1, IDX_HIGH0, 8'hFE);
    apb(1'b1, IDX_LOW1, 8'h00);
    apb(1'b1, IDX_HIGH1, 8'h00);
    run(8'h50, 8'h03);
    check(irq, 1'b1);
    rd_chk(IDX_LOW0, 32'h01);
    rd_chk(IDX_HIGH0, 32'h01);
    rd_chk(IDX_LOW1, 32'h03);
    rd_chk(IDX_IRQ_STAT, 32'h3);
    repeat (2) @(posedge pclk);
    check(irq, 1'b0);
    apb(1'b1, IDX_CTRL, 8'hA0);
    repeat (2) @(posedge pclk);
    check({ovf1, ovf0}, 2'h3);
    ack0 <= 1'b1;
    ack1 <= 1'b1;
    @(posedge pclk);
    ack0 <= 1'b0;
    ack1 <= 1'b0;
    repeat (2) @(posedge pclk);
    check({ovf1, ovf0}, 2'h0);
    // ce low stops the machine-cycle count: only 12 ce-high run edges add
    apb(1'b1, IDX_MODE, 8'h01);
    apb(1'b1, IDX_LOW0, 8'hFF);
    apb(1'b1, IDX_HIGH0, 8'h00);
    apb(1'b1, IDX_CTRL, 8'h10);
    ce <= 1'b0;
    repeat (30) @(posedge pclk);
    ce <= 1'b1;
    repeat (9) @(posedge pclk);
    apb(1'b1, IDX_CTRL, 8'h00);
    rd_chk(IDX_LOW0, 32'h01);
    rd_chk(IDX_HIGH0, 32'h01);
    // second reset with state loaded: everything returns to zero
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check({ovf1, ovf0, irq}, 32'h0);
    foreach (regs[i]) rd_chk(regs[i], 32'h0);
    results();
  end
endmodule : testbench
`default_nettype wire
